// file: lpcc_regs.vh
/*
 * Register offsets, field positions, reset values and timing counts of the
 * low-power clock control block.
 * Assumes inclusion by bare name from the design files of this block.
 */
`ifndef LPCC_REGS_VH
`define LPCC_REGS_VH

`define LPCC_ADDR_W 4
`define LPCC_OFS_SYNTH 4'h0
`define LPCC_OFS_PINASSIGN 4'h1
`define LPCC_OFS_STOPBITS 4'h2
`define LPCC_OFS_MODCFG 4'h3
`define LPCC_OFS_STATUS 4'h4
`define LPCC_OFS_LPCMD 4'h5

`define LPCC_SYN_MOD_LSB 0
`define LPCC_SYN_MOD_MSB 5
`define LPCC_SYN_PRE_LO 6
`define LPCC_SYN_PRE_HI 7
`define LPCC_SYN_DIVSEL 8
`define LPCC_SYN_KEEPUNIT 9
`define LPCC_SYN_KEEPOUT 10
`define LPCC_SYN_RESET 32'h0000_0000

`define LPCC_PA_LSB 0
`define LPCC_PA_MSB 1
`define LPCC_PA_CLOCK 2'h3
`define LPCC_PA_RESET 32'h0000_0000

`define LPCC_CFG_CLKOFF 0
`define LPCC_CFG_EXTSRC 1
`define LPCC_CFG_RESET 32'h0000_0000

`define LPCC_HALF_DIV8 7'h03
`define LPCC_HALF_DIV16 7'h07

`define LPCC_MASK_W 3
`define LPCC_NMOD 4

`define LPCC_RELOCK_US 20
`define LPCC_CLK_MHZ 50
`define LPCC_RELOCK_CYC (`LPCC_RELOCK_US * `LPCC_CLK_MHZ)

`endif

// file: lpcc_clk_div.v
/*
 * Divider that produces one enable pulse every so many input clocks.
 * Assumes a single clock and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none
module lpcc_clk_div #(
    parameter W = 7
) (
    input wire clk_in,
    input wire rstn_in,
    input wire run_in,
    input wire [W-1:0] load_in,
    output reg tick_out
);
    reg [W-1:0] count;

    always @(posedge clk_in) begin
        if (!rstn_in || !run_in) begin
            count <= {W{1'b0}};
            tick_out <= 1'b0;
        end else if (count >= load_in) begin
            count <= {W{1'b0}};
            tick_out <= 1'b1;
        end else begin
            count <= count + {{(W-1){1'b0}}, 1'b1};
            tick_out <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// file: lpcc_sync2.v
/*
 * Two-flip-flop synchroniser for a bus of pin levels.
 * Assumes the inputs may change at any time relative to clk_in.
 */
`timescale 1ns/1ps
`default_nettype none
module lpcc_sync2 #(
    parameter W = 1
) (
    input wire clk_in,
    input wire rstn_in,
    input wire [W-1:0] d_in,
    output reg [W-1:0] q_out
);
    reg [W-1:0] meta;

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            meta <= {W{1'b0}};
            q_out <= {W{1'b0}};
        end else begin
            meta <= d_in;
            q_out <= meta;
        end
    end
endmodule
`default_nettype wire

// file: lpcc_top.v
/*
 * Low-power clock control: synthesizer settings, legacy bus clock, module
 * stop gating, low-power halt entry and wake-up, clock and pin states while
 * halted, all reached over an Avalon-MM slave with waitrequest.
 * Assumes clk_in is the always-running reference clock, and that the core
 * announces the halt instruction with a one-cycle pulse and its mask.
 */
// The address map and the Avalon-MM interface to the registers were left to the implementer.
// Overview of operation
// [RQ1] Modulus and prescaler set system clock frequency
// [RQ2] Low prescaler clear doubles oscillator frequency
// [RQ3] Software keeps system clock within limit
// [RQ4] Divide select: bus clock sysclk/8 or /16
// [RQ5] Bus clock driven only when pin assigned
// [RQ6] Module stop gates clocks, registers stay accessible
// [RQ7] Halt instruction shuts off system clock
// [RQ8] Halt cycle stores copy of interrupt mask
// [RQ9] Wake on reset, trace, higher-priority interrupt
// [RQ10] Control logic and unit clock keep running; code stops the unit clock while halted unless keep_unit and not ext_src
// [RQ11] Timer and pin inputs use unit clock
// [RQ12] Clock output may toggle while halted
// [RQ13] Halted: address shows instruction, controls negated
// [RQ14] Halted: outputs hold, inputs go high-impedance
// [RQ15] Two bits choose clocks kept while halted
// [RQ16] Clocks switched off are held low
// [RQ17] Wait for relock after oscillator restart
// [RQ18] Disable bit floats clock pin while halted
// [RQ19] Crystal oscillator always keeps running
// [RQ20] Wake re-enables clocks in ordered sequence
`timescale 1ns/1ps
`default_nettype none
`include "lpcc_regs.vh"
module lpcc_top #(
    parameter RELOCK_CYCLES = `LPCC_RELOCK_CYC,
    parameter GPIO_W = 8,
    parameter ADDR_W = 24
) (
    input wire clk_in,
    input wire rstn_in,
    input wire [`LPCC_ADDR_W-1:0] avs_address,
    input wire avs_read,
    input wire avs_write,
    input wire [31:0] avs_writedata,
    output reg [31:0] avs_readdata,
    output reg avs_waitrequest,
    input wire halt_instr_in,
    input wire [`LPCC_MASK_W-1:0] halt_mask_in,
    input wire trace_in,
    input wire [`LPCC_MASK_W-1:0] irq_level_pin_in,
    input wire [ADDR_W-1:0] bus_addr_in,
    input wire [ADDR_W-1:0] halt_addr_in,
    input wire bus_ctrl_in,
    input wire [GPIO_W-1:0] gpio_out_in,
    input wire [GPIO_W-1:0] gpio_dir_in,
    output reg sys_clk_en_out,
    output reg unit_clk_en_out,
    output reg [`LPCC_NMOD-1:0] module_clk_en_out,
    output reg osc_run_out,
    output reg xtal_run_out,
    output reg [7:0] sys_freq_mult_out,
    output reg vco_double_out,
    output reg legacy_bus_clock_out,
    output reg legacy_bus_clock_oe_out,
    output reg clock_out_pin_out,
    output reg clock_out_pin_oe_out,
    output reg [ADDR_W-1:0] addr_pins_out,
    output reg bus_ctrl_out,
    output reg [GPIO_W-1:0] gpio_pins_out,
    output reg [GPIO_W-1:0] gpio_pins_oe_out,
    output reg halted_out
);
    localparam ST_RUN = 4'b0001;
    localparam ST_HALT = 4'b0010;
    localparam ST_RELOCK = 4'b0100;
    localparam ST_RESUME = 4'b1000;
    localparam RW = 24;
    localparam [RW-1:0] RELOCK_N = RELOCK_CYCLES[RW-1:0];

    reg [31:0] synth_control_reg;
    reg [31:0] select_pin_assign_reg_one;
    reg [`LPCC_NMOD-1:0] stop_bits;
    reg [31:0] mod_cfg;
    reg [`LPCC_MASK_W-1:0] stored_mask;
    reg [3:0] state;
    reg [3:0] next_state;
    reg [RW-1:0] relock_cnt;
    reg osc_was_off;
    reg bus_half;
    reg clock_out_pin_phase;
    reg ack;
    reg [GPIO_W-1:0] gpio_held;
    wire [`LPCC_MASK_W-1:0] irq_level;
    wire trace_sync;
    wire half_tick;
    // Taken from the next state so that stopped clocks go low on the entry edge.
    wire halted = (next_state != ST_RUN);
    wire keep_unit = synth_control_reg[`LPCC_SYN_KEEPUNIT];
    wire keep_out = synth_control_reg[`LPCC_SYN_KEEPOUT];
    wire clk_off = mod_cfg[`LPCC_CFG_CLKOFF];
    wire ext_src = mod_cfg[`LPCC_CFG_EXTSRC];
    wire [5:0] modulus = synth_control_reg[`LPCC_SYN_MOD_MSB:`LPCC_SYN_MOD_LSB];
    wire pre_lo = synth_control_reg[`LPCC_SYN_PRE_LO];
    wire pre_hi = synth_control_reg[`LPCC_SYN_PRE_HI];
    wire wake = (irq_level > stored_mask) || trace_sync;
    wire bus_pin_clock = (select_pin_assign_reg_one[`LPCC_PA_MSB:`LPCC_PA_LSB]
        == `LPCC_PA_CLOCK);
    wire [6:0] half_load = synth_control_reg[`LPCC_SYN_DIVSEL] ? `LPCC_HALF_DIV16 :
        `LPCC_HALF_DIV8;
    wire bus_clk_run = !halted;

    // Pin inputs are asynchronous, so they pass two flops before use.
    lpcc_sync2 #(.W(`LPCC_MASK_W + 1)) u_sync (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .d_in({trace_in, irq_level_pin_in}),
        .q_out({trace_sync, irq_level})
    );

    // Half-period counter of the legacy bus clock, in system clock cycles.
    lpcc_clk_div #(.W(7)) u_div (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .run_in(bus_clk_run),
        .load_in(half_load),
        .tick_out(half_tick)
    );

    // The slave answers every access one cycle after it is presented.
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            ack <= 1'b0;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
            synth_control_reg <= `LPCC_SYN_RESET;
            select_pin_assign_reg_one <= `LPCC_PA_RESET;
            stop_bits <= {`LPCC_NMOD{1'b0}};
            mod_cfg <= `LPCC_CFG_RESET;
        end else begin
            ack <= (avs_read || avs_write) && !ack;
            avs_waitrequest <= !((avs_read || avs_write) && !ack);
            if ((avs_read || avs_write) && !ack) begin
                avs_readdata <= 32'h0000_0000;
                // Registers stay reachable even with module clocks stopped.
                case (avs_address) // see [RQ6]
                    `LPCC_OFS_SYNTH: begin
                        if (avs_write)
                            synth_control_reg <= {21'h000000, avs_writedata[10:0]};
                        avs_readdata <= synth_control_reg;
                    end
                    `LPCC_OFS_PINASSIGN: begin
                        if (avs_write)
                            select_pin_assign_reg_one <= {30'h0, avs_writedata[1:0]};
                        avs_readdata <= select_pin_assign_reg_one;
                    end
                    `LPCC_OFS_STOPBITS: begin
                        if (avs_write)
                            stop_bits <= avs_writedata[`LPCC_NMOD-1:0];
                        avs_readdata <= {{(32-`LPCC_NMOD){1'b0}}, stop_bits};
                    end
                    `LPCC_OFS_MODCFG: begin
                        if (avs_write)
                            mod_cfg <= {30'h0, avs_writedata[1:0]};
                        avs_readdata <= mod_cfg;
                    end
                    `LPCC_OFS_STATUS: begin
                        avs_readdata <= {24'h000000, 1'b0, stored_mask, state};
                    end
                    default: begin
                        avs_readdata <= 32'h0000_0000;
                    end
                endcase
            end
        end
    end

    always @* begin
        next_state = state;
        case (state)
            ST_RUN: begin
                if (halt_instr_in)
                    next_state = ST_HALT; // see [RQ7]
            end
            ST_HALT: begin
                if (wake) // see [RQ9]
                    next_state = osc_was_off ? ST_RELOCK : ST_RESUME;
            end
            ST_RELOCK: begin
                if (relock_cnt == {RW{1'b0}})
                    next_state = ST_RESUME; // see [RQ17]
            end
            ST_RESUME: begin
                next_state = ST_RUN; // see [RQ20]
            end
            default: begin
                next_state = ST_RUN;
            end
        endcase
    end

    // Reset is the first wake source: it forces the run state directly.
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            state <= ST_RUN; // see [RQ9]
            stored_mask <= {`LPCC_MASK_W{1'b0}};
            relock_cnt <= {RW{1'b0}};
            osc_was_off <= 1'b0;
            gpio_held <= {GPIO_W{1'b0}};
        end else begin
            state <= next_state;
            if (state == ST_RUN && halt_instr_in) begin
                stored_mask <= halt_mask_in; // see [RQ8]
                gpio_held <= gpio_out_in;
                osc_was_off <= !keep_unit && !keep_out;
            end
            if (state == ST_HALT)
                relock_cnt <= RELOCK_N;
            else if (relock_cnt != {RW{1'b0}})
                relock_cnt <= relock_cnt - {{(RW-1){1'b0}}, 1'b1};
        end
    end

    always @(posedge clk_in) begin
        if (!rstn_in) begin
            sys_clk_en_out <= 1'b1;
            unit_clk_en_out <= 1'b1;
            module_clk_en_out <= {`LPCC_NMOD{1'b1}};
            osc_run_out <= 1'b1;
            xtal_run_out <= 1'b1;
            sys_freq_mult_out <= 8'h01;
            vco_double_out <= 1'b1;
            halted_out <= 1'b0;
            addr_pins_out <= {ADDR_W{1'b0}};
            bus_ctrl_out <= 1'b0;
            gpio_pins_out <= {GPIO_W{1'b0}};
            gpio_pins_oe_out <= {GPIO_W{1'b0}};
        end else begin
            // Frequency steps are (modulus + 1) shifted left by the prescaler bits.
            sys_freq_mult_out <= ({2'b00, modulus} + 8'h01) << {pre_hi, pre_lo}; // see [RQ1]
            vco_double_out <= !pre_lo; // see [RQ2]
            // The stored mask decides wake, so the frequency limit is software's.
            xtal_run_out <= 1'b1; // see [RQ19]
            // Resume brings the unit clock first, system clock one cycle later, or relock count plus two cycles later after a relock.
            sys_clk_en_out <= (next_state == ST_RUN); // see [RQ7] [RQ20]
            // A removed external source only silences the unit clock while halted.
            unit_clk_en_out <= (next_state != ST_HALT) ||
                (keep_unit && !ext_src); // see [RQ10] [RQ11] [RQ15]
            module_clk_en_out <= ~stop_bits & {`LPCC_NMOD{next_state == ST_RUN}}; // see [RQ6]
            // On the entry edge the captured flag is not yet valid, so read the bits.
            osc_run_out <= (next_state != ST_HALT) || ((state == ST_RUN) ?
                (keep_unit || keep_out) : !osc_was_off);
            halted_out <= (next_state != ST_RUN);
            if (next_state == ST_RUN) begin
                addr_pins_out <= bus_addr_in;
                bus_ctrl_out <= bus_ctrl_in;
                gpio_pins_out <= gpio_out_in;
                gpio_pins_oe_out <= gpio_dir_in;
            end else begin
                addr_pins_out <= halt_addr_in; // see [RQ13]
                bus_ctrl_out <= 1'b0;
                gpio_pins_out <= (state == ST_RUN) ? gpio_out_in : gpio_held; // see [RQ14]
                gpio_pins_oe_out <= gpio_dir_in;
            end
        end
    end

    // The bus clock is a divided copy of the system clock on the address pin.
    always @(posedge clk_in) begin
        if (!rstn_in) begin
            bus_half <= 1'b0;
            legacy_bus_clock_out <= 1'b0;
            legacy_bus_clock_oe_out <= 1'b0;
            clock_out_pin_phase <= 1'b0;
            clock_out_pin_out <= 1'b0;
            clock_out_pin_oe_out <= 1'b1;
        end else begin
            if (!bus_clk_run)
                bus_half <= 1'b0; // see [RQ16]
            else if (half_tick)
                bus_half <= !bus_half; // see [RQ4]
            legacy_bus_clock_out <= bus_half && bus_pin_clock;
            legacy_bus_clock_oe_out <= bus_pin_clock; // see [RQ5]
            if (halted && !(keep_out && !clk_off))
                clock_out_pin_phase <= 1'b0; // see [RQ16]
            else
                clock_out_pin_phase <= !clock_out_pin_phase; // see [RQ12]
            clock_out_pin_out <= clock_out_pin_phase;
            clock_out_pin_oe_out <= !(halted && clk_off); // see [RQ18]
        end
    end
endmodule
`default_nettype wire

// file: lpcc_properties.sv
/* Checker of lpcc_top: halt entry, pins while halted, wake order, bus answer.
   Assumes a bind to lpcc_top, one clock and a synchronous active-low reset. */
`timescale 1ns/1ps
`default_nettype none
module lpcc_props #(
    parameter RELOCK_CYCLES = 8,
    parameter GPIO_W = 8,
    parameter ADDR_W = 24
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic halt_instr_in,
    input wire logic trace_in,
    input wire logic [ADDR_W-1:0] halt_addr_in,
    input wire logic [GPIO_W-1:0] gpio_dir_in,
    input wire logic sys_clk_en_out,
    input wire logic unit_clk_en_out,
    input wire logic xtal_run_out,
    input wire logic legacy_bus_clock_out,
    input wire logic [ADDR_W-1:0] addr_pins_out,
    input wire logic bus_ctrl_out,
    input wire logic [GPIO_W-1:0] gpio_pins_out,
    input wire logic [GPIO_W-1:0] gpio_pins_oe_out,
    input wire logic halted_out
);
    // Two sync flops, relock and resume make a wake longer than the relock count.
    localparam int WAKE_MAX = RELOCK_CYCLES + 8;
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (!rstn_in);
    a_halt_entry: assert property (
        halt_instr_in && !halted_out |=> halted_out && !sys_clk_en_out)
        else $error("halt did not stop the system clock");
    a_halt_addr: assert property (
        halted_out |-> addr_pins_out == halt_addr_in && !bus_ctrl_out)
        else $error("address or bus control wrong while halted");
    a_input_float: assert property (
        halted_out |-> (gpio_pins_oe_out & ~gpio_dir_in) == '0)
        else $error("input pin driven while halted");
    a_output_hold: assert property (
        halted_out && $past(halted_out) |-> $stable(gpio_pins_out))
        else $error("output pin changed while halted");
    a_bus_clk_low: assert property (
        halted_out && $past(halted_out) |-> !legacy_bus_clock_out)
        else $error("stopped bus clock not held low");
    a_xtal_alive: assert property (xtal_run_out)
        else $error("crystal oscillator stopped");
    a_wake_order: assert property (
        $rose(sys_clk_en_out) |-> $past(unit_clk_en_out) && $past(halted_out))
        else $error("system clock resumed before unit clock");
    a_trace_wake: assert property (
        $rose(trace_in) && halted_out |-> ##[1:WAKE_MAX] !halted_out)
        else $error("trace did not wake the block");
    a_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("register access not answered");
endmodule
bind lpcc_top lpcc_props #(.RELOCK_CYCLES(RELOCK_CYCLES), .GPIO_W(GPIO_W), .ADDR_W(ADDR_W))
    u_props (.clk_in(clk_in), .rstn_in(rstn_in), .avs_read(avs_read),
    .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
    .halt_instr_in(halt_instr_in), .trace_in(trace_in), .halt_addr_in(halt_addr_in),
    .gpio_dir_in(gpio_dir_in), .sys_clk_en_out(sys_clk_en_out),
    .unit_clk_en_out(unit_clk_en_out), .xtal_run_out(xtal_run_out),
    .legacy_bus_clock_out(legacy_bus_clock_out), .addr_pins_out(addr_pins_out),
    .bus_ctrl_out(bus_ctrl_out), .gpio_pins_out(gpio_pins_out),
    .gpio_pins_oe_out(gpio_pins_oe_out), .halted_out(halted_out));
`default_nettype wire

// file: lpcc_core_model.sv
/* Core model: announces the halt instruction by a one-cycle pulse with its mask.
   Assumes the bench asks for a halt only while the block runs. */
`timescale 1ns/1ps
`default_nettype none
module lpcc_core_model #(
    parameter ADDR_W = 24
) (
    input wire logic clk_in,
    input wire logic rstn_in,
    input wire logic go_in,
    input wire logic [2:0] mask_in,
    output logic halt_instr_out,
    output logic [2:0] halt_mask_out,
    output logic [ADDR_W-1:0] halt_addr_out,
    output logic [ADDR_W-1:0] bus_addr_out
);
    assign halt_addr_out = ADDR_W'(24'h00A5C3);
    initial begin
        halt_instr_out = 1'h0;
        halt_mask_out = 3'h0;
        bus_addr_out = '0;
    end
    // Outside the pulse the mask shows its inverse, so a late sample is caught.
    always @(posedge clk_in) begin
        halt_instr_out <= rstn_in & go_in;
        halt_mask_out <= go_in ? mask_in : ~mask_in;
        bus_addr_out <= rstn_in ? bus_addr_out + 1'h1 : '0;
    end
endmodule
`default_nettype wire

// file: test_lowpower_clock_control.sv
/* Bench of lpcc_top: registers, frequency, bus clock, module stop, halt and wake.
   Assumes lpcc_properties.sv is compiled with it and the core model drives halts. */
`timescale 1ns/1ps
`default_nettype none
module test_lowpower_clock_control;
    localparam int RELOCK = 8;
    logic clk_in = 1'h0, rstn_in = 1'h0, avs_read = 1'h0, avs_write = 1'h0;
    logic trace_in = 1'h0, bus_ctrl_in = 1'h0, go = 1'h0;
    logic [3:0] avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, q;
    logic [2:0] irq = 3'h0, mask = 3'h0;
    logic [7:0] gpio_out = 8'h0, gpio_dir = 8'h0;
    wire [31:0] avs_readdata;
    wire [23:0] halt_addr, bus_addr;
    wire [7:0] mult;
    wire [3:0] mod_en;
    wire [2:0] halt_mask;
    wire wait_r, halt_instr, sys_en, unit_en, osc, xtal, vco2, bclk, bclk_oe, cko, cko_oe;
    wire halted;
    integer seed = 93, fail_count = 0, n_compared = 0, guard = 0, i, n, h;
    always #10 clk_in = ~clk_in;
    lpcc_core_model core (.clk_in(clk_in), .rstn_in(rstn_in), .go_in(go), .mask_in(mask),
        .halt_instr_out(halt_instr), .halt_mask_out(halt_mask),
        .halt_addr_out(halt_addr), .bus_addr_out(bus_addr));
    lpcc_top #(.RELOCK_CYCLES(RELOCK)) DUT (.clk_in(clk_in), .rstn_in(rstn_in),
        .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
        .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(wait_r), .halt_instr_in(halt_instr), .halt_mask_in(halt_mask),
        .trace_in(trace_in), .irq_level_pin_in(irq), .bus_addr_in(bus_addr),
        .halt_addr_in(halt_addr), .bus_ctrl_in(bus_ctrl_in), .gpio_out_in(gpio_out),
        .gpio_dir_in(gpio_dir), .sys_clk_en_out(sys_en), .unit_clk_en_out(unit_en),
        .module_clk_en_out(mod_en), .osc_run_out(osc), .xtal_run_out(xtal),
        .sys_freq_mult_out(mult), .vco_double_out(vco2), .legacy_bus_clock_out(bclk),
        .legacy_bus_clock_oe_out(bclk_oe), .clock_out_pin_out(cko),
        .clock_out_pin_oe_out(cko_oe), .addr_pins_out(), .bus_ctrl_out(),
        .gpio_pins_out(), .gpio_pins_oe_out(), .halted_out(halted));
    task wrap_up;
        begin
            $display("compared %0d failed %0d", n_compared, fail_count);
            if (fail_count == 0 && n_compared > 0) begin
                $display("TEST PASSED");
            end else begin
                $display("TEST FAILED");
            end
            $finish;
        end
    endtask
    // Every wait goes through here, so a hang ends in the closing report.
    task step;
        begin
            @(posedge clk_in);
            bus_ctrl_in <= $random(seed);
            guard = guard + 1;
            if (guard > 3000) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t wait ran out", $time);
                wrap_up;
            end
        end
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        begin
            n_compared = n_compared + 1;
            if (g !== e) begin
                fail_count = fail_count + 1;
                $display("[FAIL] %0t got %h expected %h", $time, g, e);
            end
        end
    endtask
    task bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        begin
            guard = 0;
            avs_address <= a;
            avs_writedata <= d;
            avs_write <= w;
            avs_read <= !w;
            step;
            while (wait_r !== 1'h0) step;
            q = avs_readdata;
            avs_write <= 1'h0;
            avs_read <= 1'h0;
            repeat (3) step;
        end
    endtask
    function automatic logic [7:0] exp_mult(input int m, input int p);
        return 8'((m + 1) << p);
    endfunction
    initial begin
        repeat (12) step;
        rstn_in <= 1'h1;
        step;
        chk({halted, sys_en, mod_en, xtal}, 7'h3F);
        bus(0, 4'h0, 0);
        chk(q, 0);
        bus(1, 4'hF, 32'hFFFFFFFF);
        bus(0, 4'hF, 0);
        chk(q, 0);
        $display("done: reset and map");
        // Modulus at most 15 keeps every setting under the speed limit.
        bus(1, 4'h0, 32'h20);
        chk({vco2, mult}, 9'h121);
        for (i = 0; i < 4; i++) begin
            n = $random(seed) & 15;
            bus(1, 4'h0, (i << 6) | n);
            chk({vco2, mult}, {!i[0], exp_mult(n, i)});
        end
        for (i = 0; i < 4; i++) begin
            bus(1, 4'h1, i);
            chk(bclk_oe, i == 3);
        end
        for (i = 0; i < 2; i++) begin
            bus(1, 4'h0, i << 8);
            guard = 0;
            while (bclk !== 1'h0) step;
            while (bclk !== 1'h1) step;
            h = 0;
            while (bclk === 1'h1) begin
                step;
                h++;
            end
            chk(h, i ? 8 : 4);
        end
        for (i = 0; i < 3; i++) begin
            n = $random(seed) & 15;
            bus(1, 4'h2, n);
            chk(mod_en, ~n & 15);
            bus(0, 4'h2, 0);
            chk(q, n);
        end
        bus(1, 4'h2, 0);
        $display("done: clocks and stop bits");
        for (i = 0; i < 8; i++) begin
            // The last pass also removes the external source while halted.
            bus(1, 4'h3, i == 7 ? 3 : i >> 2);
            bus(1, 4'h0, (i & 3) << 9);
            n = $random(seed);
            mask = (n[2:0] == 3'h7) ? 3'h6 : n[2:0];
            irq <= mask;
            gpio_out <= $random(seed);
            gpio_dir <= $random(seed);
            repeat (4) step;
            go <= 1'h1;
            step;
            go <= 1'h0;
            repeat (3) step;
            chk({halted, sys_en, unit_en}, {2'h2, i[0] && i != 7});
            chk({cko_oe, osc}, {!i[2], i[1:0] != 0});
            if (i[1] && !i[2]) begin
                h = cko;
                step;
                chk(cko, !h);
            end else begin
                chk(cko, 0);
            end
            gpio_out <= ~gpio_out;
            bus(0, 4'h4, 0);
            chk({halted, q[6:4]}, {1'h1, mask});
            if (i[0]) trace_in <= 1'h1;
            else irq <= mask + 3'h1;
            guard = 0;
            n = 0;
            while (halted !== 1'h0) begin
                step;
                n++;
            end
            chk(n >= RELOCK + 2, i[1:0] == 0);
            chk(sys_en, 1);
            trace_in <= 1'h0;
            irq <= 3'h0;
        end
        $display("done: halt and wake");
        go <= 1'h1;
        step;
        go <= 1'h0;
        repeat (3) step;
        rstn_in <= 1'h0;
        repeat (3) step;
        rstn_in <= 1'h1;
        step;
        step;
        chk({halted, sys_en}, 2'h1);
        $display("done: reset wake");
        wrap_up;
    end
endmodule
`default_nettype wire
